// file: core/thermal_derating_fan_control.sv
// switching frequency derating and two-stage fan control with apb registers
// Summary of operation
// R1: adaptive switching frequency always stays between minimum and nominal setting
// R2: minimum at or above nominal disables automatic reduction
// R3: nominal defaults 2 kHz characteristic, 4 kHz field-oriented, at most 16 kHz
// R4: minimum setting accepts 2 to 16 kHz, default 2 kHz
// R5: reduce above heat-sink shut-off plus offset, offset -25..0, default -4
// R6: step back up once heat sink is 5 degC below reduction threshold
// R7: with full current limits, reduce above 87.5 % of 60 s overload current
// R8: step up once current is below reference of next higher level
// R9: inside, capacitor or heat sink above switch-on runs fans at half power
// R10: digital output set to function 43 follows internal fan switch-on
// R11: fixed inside and capacitor thresholds also start fans at half power
// R12: critical temperature switches running fans to full power
// R13: internal shut-off temperature raises a device fault
// R14: fans stop only when all temperatures are 5 degC below their thresholds
// R15: standby with enable low switches internal fans off
// R16: configuring party keeps switching frequency at least ten times output frequency
// R17: comparisons run periodically, frequency moves at most one level per evaluation (code jumps to nominal or band edge when disabled or out of band)
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module thermal_derating_fan_control
  import thermal_pkg::*;
#(
  parameter int EVAL_PERIOD = EVAL_CYCLES
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // sensors and power stage
  input  wire logic signed [7:0] heatsink_temp,
  input  wire logic signed [7:0] inside_temp,
  input  wire logic signed [7:0] cap_temp,
  input  wire logic [15:0]       output_current,
  input  wire logic [15:0]       overload_current,
  input  wire logic [15:0]       next_level_current,
  input  wire logic              drive_enable,
  // outputs
  output logic [4:0]             switch_freq_khz,
  output logic [4:0]             next_level_khz,
  output logic                   fan_half,
  output logic                   fan_full,
  output logic                   ext_fan_out,
  output logic                   device_fault
);
  logic              tick;
  logic              foc_mode;
  logic              standby_en;
  logic              ilim_full;
  logic [7:0]        dout_func;
  logic [4:0]        nom_freq;
  logic [4:0]        min_freq;
  logic signed [9:0] derate_offset;
  logic signed [9:0] fan_on_temp;
  logic signed [9:0] hs_t;
  logic signed [9:0] in_t;
  logic signed [9:0] cp_t;
  logic signed [9:0] derate_thr;
  logic              reduce_en;
  logic              hot;
  logic              cool;
  logic              over_i;
  logic              under_i;
  logic [19:0]       cur_scaled;
  logic [19:0]       lim_scaled;
  logic [4:0]        next_freq;
  logic              wr_en;
  logic              rd_en;
  logic              mapped;
  logic [2:0]        on_above;
  logic [2:0]        on_active;
  logic [1:0]        fix_above;
  logic [1:0]        fix_active;
  logic              start_fans;
  logic              keep_fans;
  logic              critical;
  logic              shutoff;
  logic              fault_clr;
  fan_state_e        fan_state;
  fan_state_e        next_fan_state;

  eval_tick #(.PERIOD(EVAL_PERIOD)) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  function automatic logic [4:0] clamp_freq(input logic [31:0] v, input logic [4:0] lo);
    if (v < 32'(lo)) begin
      clamp_freq = lo;
    end else if (v > 32'(FREQ_HIGH)) begin
      clamp_freq = FREQ_HIGH;
    end else begin
      clamp_freq = v[4:0];
    end
  endfunction

  function automatic logic signed [9:0] clamp_temp(input logic [31:0] v,
                                                   input logic signed [9:0] lo,
                                                   input logic signed [9:0] hi);
    logic signed [31:0] t;
    t = $signed(v);
    if (t < 32'(lo)) begin
      clamp_temp = lo;
    end else if (t > 32'(hi)) begin
      clamp_temp = hi;
    end else begin
      clamp_temp = t[9:0];
    end
  endfunction

  // apb: zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && !pwrite;

  always_comb begin
    if (paddr == ADDR_CTRL) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_NOM_FREQ) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_MIN_FREQ) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_OFFSET) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_FAN_TEMP) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_STATUS) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end
  assign pslverr = psel && penable && !mapped;

  // configuration writes, with range clamping on the frequency, offset and fan temperature settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      foc_mode      <= 1'b0;
      standby_en    <= 1'b0;
      ilim_full     <= 1'b1;
      dout_func     <= 8'h00;
      nom_freq      <= NOM_CHAR_DEF;                                       // R3
      min_freq      <= MIN_DEF;                                            // R4
      derate_offset <= OFFSET_DEF;                                         // R5
      fan_on_temp   <= FAN_ON_DEF;                                         // R9
    end else if (wr_en && mapped) begin
      if (paddr == ADDR_CTRL) begin
        foc_mode   <= pwdata[CTRL_FOC_BIT];
        standby_en <= pwdata[CTRL_STANDBY_BIT];
        ilim_full  <= pwdata[CTRL_ILIM_BIT];
        dout_func  <= pwdata[CTRL_DOUT_LSB +: CTRL_DOUT_W];
        if (pwdata[CTRL_FOC_BIT] != foc_mode) begin
          nom_freq <= pwdata[CTRL_FOC_BIT] ? NOM_FOC_DEF : NOM_CHAR_DEF;   // R3
        end
      end else if (paddr == ADDR_NOM_FREQ) begin
        nom_freq <= clamp_freq(pwdata, foc_mode ? FREQ_FOC_MIN : FREQ_LOW); // R3
      end else if (paddr == ADDR_MIN_FREQ) begin
        min_freq <= clamp_freq(pwdata, FREQ_LOW);                          // R4
      end else if (paddr == ADDR_OFFSET) begin
        derate_offset <= clamp_temp(pwdata, OFFSET_MIN, OFFSET_MAX);       // R5
      end else if (paddr == ADDR_FAN_TEMP) begin
        fan_on_temp <= clamp_temp(pwdata, FAN_ON_MIN, FAN_ON_MAX);         // R9
      end
    end
  end

  // read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en && !penable) begin
      prdata <= 32'h00000000;
      if (paddr == ADDR_CTRL) begin
        prdata[CTRL_FOC_BIT]                <= foc_mode;
        prdata[CTRL_STANDBY_BIT]            <= standby_en;
        prdata[CTRL_ILIM_BIT]               <= ilim_full;
        prdata[CTRL_DOUT_LSB +: CTRL_DOUT_W] <= dout_func;
      end else if (paddr == ADDR_NOM_FREQ) begin
        prdata[4:0] <= nom_freq;
      end else if (paddr == ADDR_MIN_FREQ) begin
        prdata[4:0] <= min_freq;
      end else if (paddr == ADDR_OFFSET) begin
        prdata <= 32'($signed(derate_offset));
      end else if (paddr == ADDR_FAN_TEMP) begin
        prdata <= 32'($signed(fan_on_temp));
      end else if (paddr == ADDR_STATUS) begin
        prdata[STAT_FREQ_LSB +: 5] <= switch_freq_khz;
        prdata[STAT_HALF_BIT]      <= fan_half;
        prdata[STAT_FULL_BIT]      <= fan_full;
        prdata[STAT_FAULT_BIT]     <= device_fault;
        prdata[STAT_EXT_BIT]       <= ext_fan_out;
      end
    end
  end

  // derating decisions
  assign hs_t       = 10'(heatsink_temp);
  assign in_t       = 10'(inside_temp);
  assign cp_t       = 10'(cap_temp);
  assign reduce_en  = min_freq < nom_freq;                                 // R2
  assign derate_thr = HS_SHUTOFF + derate_offset;                          // R5
  assign hot        = hs_t > derate_thr;                                   // R5
  assign cool       = hs_t < derate_thr - HYST;                            // R6
  assign cur_scaled = 20'(output_current) * 20'(ILIM_DEN);
  assign lim_scaled = 20'(overload_current) * 20'(ILIM_NUM);
  assign over_i     = ilim_full && (cur_scaled > lim_scaled);              // R7
  assign under_i    = !ilim_full || (output_current < next_level_current); // R8

  always_comb begin
    if (switch_freq_khz + FREQ_STEP > nom_freq) begin
      next_level_khz = nom_freq;
    end else begin
      next_level_khz = switch_freq_khz + FREQ_STEP;
    end
  end

  always_comb begin
    next_freq = switch_freq_khz;
    if (!reduce_en) begin
      next_freq = nom_freq;                                                // R2
    end else if (switch_freq_khz > nom_freq) begin
      next_freq = nom_freq;                                                // R1
    end else if (switch_freq_khz < min_freq) begin
      next_freq = min_freq;                                                // R1
    end else if (hot || over_i) begin
      if (switch_freq_khz >= min_freq + FREQ_STEP) begin
        next_freq = switch_freq_khz - FREQ_STEP;                           // R17
      end else begin
        next_freq = min_freq;
      end
    end else if (cool && under_i) begin
      next_freq = next_level_khz;                                          // R6 R8
    end
  end

  // one level per evaluation in band with reduction on, else straight to nominal or band edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_freq_khz <= NOM_CHAR_DEF;
    end else if (tick) begin
      switch_freq_khz <= next_freq;                                        // R17
    end
  end

  // fan thresholds: switch-on temperature for all three sensors
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_on
      hyst_cmp u_cmp (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .value   (g == 0 ? hs_t : (g == 1 ? in_t : cp_t)),
        .on_thr  (fan_on_temp),
        .hyst    (HYST),
        .above   (on_above[g]),
        .active  (on_active[g])
      );
    end
  endgenerate

  // fixed internal thresholds for inside and capacitor
  hyst_cmp u_fix_in (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .value   (in_t),
    .on_thr  (INSIDE_ON),
    .hyst    (HYST),
    .above   (fix_above[0]),
    .active  (fix_active[0])
  );
  hyst_cmp u_fix_cap (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .value   (cp_t),
    .on_thr  (CAP_ON),
    .hyst    (HYST),
    .above   (fix_above[1]),
    .active  (fix_active[1])
  );

  assign start_fans = |on_above || |fix_above;                             // R9 R11
  assign keep_fans  = |on_active || |fix_active;                           // R14
  assign critical   = hs_t >= CRITICAL || in_t >= CRITICAL || cp_t >= CRITICAL;
  assign shutoff    = hs_t >= DEV_SHUTOFF || in_t >= DEV_SHUTOFF ||
                      cp_t >= DEV_SHUTOFF;

  always_comb begin
    next_fan_state = fan_state;
    case (fan_state)
      FAN_OFF: begin
        if (start_fans) begin
          next_fan_state = FAN_HALF;                                       // R9 R11
        end
      end
      FAN_HALF: begin
        if (critical) begin
          next_fan_state = FAN_FULL;                                       // R12
        end else if (!start_fans && !keep_fans) begin
          next_fan_state = FAN_OFF;                                        // R14
        end
      end
      FAN_FULL: begin
        if (!start_fans && !keep_fans) begin
          next_fan_state = FAN_OFF;                                        // R14
        end else if (!critical) begin
          next_fan_state = FAN_HALF;
        end
      end
      default: next_fan_state = FAN_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fan_state <= FAN_OFF;
    end else if (tick) begin
      fan_state <= next_fan_state;
    end
  end

  // fan outputs, fan_half and fan_full gated off in standby, ext_fan_out not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fan_half    <= 1'b0;
      fan_full    <= 1'b0;
      ext_fan_out <= 1'b0;
    end else begin
      fan_half    <= fan_state == FAN_HALF && !(standby_en && !drive_enable);  // R15
      fan_full    <= fan_state == FAN_FULL && !(standby_en && !drive_enable);  // R15
      ext_fan_out <= dout_func == DOUT_EXT_FAN && fan_state != FAN_OFF;        // R10
    end
  end

  // sticky fault, a new shut-off event wins over a clear
  assign fault_clr = wr_en && paddr == ADDR_STATUS && pwdata[STAT_FAULT_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_fault <= 1'b0;
    end else if (shutoff) begin
      device_fault <= 1'b1;                                                // R13
    end else if (fault_clr) begin
      device_fault <= 1'b0;
    end
  end

  a_freq_band: assert property (@(posedge pclk) disable iff (!presetn) // R1
    reduce_en && $past(tick) && $past(reduce_en) && $past(nom_freq) == nom_freq &&
    $past(min_freq) == min_freq |-> switch_freq_khz inside {[min_freq:nom_freq]})
    else $error("switching frequency outside band");
  a_no_reduce: assert property (@(posedge pclk) disable iff (!presetn) // R2
    tick && !reduce_en |=> switch_freq_khz == $past(nom_freq))
    else $error("reduction active while disabled");
  a_nom_range: assert property (@(posedge pclk) disable iff (!presetn) // R3
    nom_freq <= FREQ_HIGH && nom_freq >= (foc_mode ? FREQ_FOC_MIN : FREQ_LOW))
    else $error("nominal frequency out of range");
  a_min_range: assert property (@(posedge pclk) disable iff (!presetn) // R4
    min_freq inside {[FREQ_LOW:FREQ_HIGH]})
    else $error("minimum frequency out of range");
  a_hot_reduce: assert property (@(posedge pclk) disable iff (!presetn) // R5
    tick && reduce_en && hot && switch_freq_khz > min_freq &&
    switch_freq_khz <= nom_freq |=> switch_freq_khz < $past(switch_freq_khz))
    else $error("no reduction above threshold");
  a_step_one: assert property (@(posedge pclk) disable iff (!presetn) // R17
    tick && reduce_en && switch_freq_khz inside {[min_freq:nom_freq]} |=>
    switch_freq_khz + FREQ_STEP >= $past(switch_freq_khz) &&
    switch_freq_khz <= $past(switch_freq_khz) + FREQ_STEP)
    else $error("frequency moved more than one level");
  a_up_cool: assert property (@(posedge pclk) disable iff (!presetn) // R6 R8
    $past(tick) && switch_freq_khz > $past(switch_freq_khz) && $past(reduce_en) &&
    $past(switch_freq_khz) >= $past(min_freq) |->
    $past(cool) && $past(under_i) && !$past(hot) && !$past(over_i))
    else $error("frequency raised while not cool");
  a_fault_set: assert property (@(posedge pclk) disable iff (!presetn) // R13
    shutoff |=> device_fault)
    else $error("fault not raised at shut-off");
  a_standby_off: assert property (@(posedge pclk) disable iff (!presetn) // R15
    standby_en && !drive_enable |=> !fan_half && !fan_full)
    else $error("fans running in standby");
  a_ext_fan: assert property (@(posedge pclk) disable iff (!presetn) // R10
    dout_func == DOUT_EXT_FAN && fan_state != FAN_OFF |=> ext_fan_out)
    else $error("external fan output missing");
endmodule

// file: include/thermal_pkg.sv
// constants for the thermal derating and fan control block
package thermal_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_NOM_FREQ = 8'h04;
  localparam logic [7:0] ADDR_MIN_FREQ = 8'h08;
  localparam logic [7:0] ADDR_OFFSET   = 8'h0C;
  localparam logic [7:0] ADDR_FAN_TEMP = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;
  // control register fields
  localparam int CTRL_FOC_BIT     = 0;
  localparam int CTRL_STANDBY_BIT = 1;
  localparam int CTRL_ILIM_BIT    = 2;
  localparam int CTRL_DOUT_LSB    = 8;
  localparam int CTRL_DOUT_W      = 8;
  localparam logic [7:0] DOUT_EXT_FAN = 8'h2B;
  // status register fields
  localparam int STAT_FREQ_LSB  = 0;
  localparam int STAT_HALF_BIT  = 8;
  localparam int STAT_FULL_BIT  = 9;
  localparam int STAT_FAULT_BIT = 10;
  localparam int STAT_EXT_BIT   = 11;
  // switching frequency in kHz
  localparam logic [4:0] FREQ_LOW     = 5'h02;
  localparam logic [4:0] FREQ_FOC_MIN = 5'h04;
  localparam logic [4:0] FREQ_HIGH    = 5'h10;
  localparam logic [4:0] FREQ_STEP    = 5'h02;
  localparam logic [4:0] NOM_CHAR_DEF = 5'h02;
  localparam logic [4:0] NOM_FOC_DEF  = 5'h04;
  localparam logic [4:0] MIN_DEF      = 5'h02;
  // temperatures in degC, 10 bit signed arithmetic
  localparam logic signed [9:0] OFFSET_MIN  = -10'sd25;
  localparam logic signed [9:0] OFFSET_MAX  = 10'sd0;
  localparam logic signed [9:0] OFFSET_DEF  = -10'sd4;
  localparam logic signed [9:0] FAN_ON_MIN  = 10'sd0;
  localparam logic signed [9:0] FAN_ON_MAX  = 10'sd60;
  localparam logic signed [9:0] FAN_ON_DEF  = 10'sd30;
  localparam logic signed [9:0] HYST        = 10'sd5;
  localparam logic signed [9:0] HS_SHUTOFF  = 10'sd90;
  localparam logic signed [9:0] INSIDE_ON   = 10'sd55;
  localparam logic signed [9:0] CAP_ON      = 10'sd60;
  localparam logic signed [9:0] CRITICAL    = 10'sd75;
  localparam logic signed [9:0] DEV_SHUTOFF = 10'sd85;
  // overload current fraction 7/8 = 87.5 %
  localparam int ILIM_NUM = 7;
  localparam int ILIM_DEN = 8;
  // evaluation period
  localparam int CLK_MHZ       = 100;
  localparam int EVAL_PERIOD_US = 1000;
  localparam int EVAL_CYCLES   = EVAL_PERIOD_US * CLK_MHZ;
  typedef enum logic [2:0] {
    FAN_OFF  = 3'b001,
    FAN_HALF = 3'b010,
    FAN_FULL = 3'b100
  } fan_state_e;
endpackage

// file: core/eval_tick.sv
// divider giving a one-cycle evaluation enable
`timescale 1ns/1ps
module eval_tick #(
  parameter int PERIOD = 100000
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // enable pulse
  output logic      tick
);
  logic [31:0] count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 32'h00000000;
      tick  <= 1'b0;
    end else if (count >= 32'(PERIOD - 1)) begin
      count <= 32'h00000000;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h00000001;
      tick  <= 1'b0;
    end
  end
endmodule

// file: core/hyst_cmp.sv
// comparator with switch-on threshold and switch-off hysteresis
`timescale 1ns/1ps
module hyst_cmp (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              tick,
  // compare
  input  wire logic signed [9:0] value,
  input  wire logic signed [9:0] on_thr,
  input  wire logic signed [9:0] hyst,
  output logic                   above,
  output logic                   active
);
  assign above = value > on_thr;

  // active sets above the threshold and clears only hyst below it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= 1'b0;
    end else if (tick) begin
      if (above) begin
        active <= 1'b1;
      end else if (value < on_thr - hyst) begin
        active <= 1'b0;
      end
    end
  end
endmodule

// file: test/thermal_plant_model.sv
// sensors and power stage seen from the derating block
`timescale 1ns/1ps
module thermal_plant_model (
  // clock
  input  wire logic              pclk,
  // commanded plant conditions
  input  wire logic signed [7:0] hs_cmd,
  input  wire logic signed [7:0] in_cmd,
  input  wire logic signed [7:0] cap_cmd,
  input  wire logic [15:0]       cur_cmd,
  // level queried by the block
  input  wire logic [4:0]        next_level_khz,
  // sensor and current measurements
  output logic signed [7:0]      heatsink_temp,
  output logic signed [7:0]      inside_temp,
  output logic signed [7:0]      cap_temp,
  output logic [15:0]            output_current,
  output logic [15:0]            overload_current,
  output logic [15:0]            next_level_current
);
  // measurements settle one cycle after the plant changes
  always_ff @(posedge pclk) begin
    heatsink_temp    <= hs_cmd;
    inside_temp      <= in_cmd;
    cap_temp         <= cap_cmd;
    output_current   <= cur_cmd;
    overload_current <= 16'h0320;
  end
  // higher switching levels allow less current
  always_ff @(posedge pclk) begin
    next_level_current <= 16'h0384 - 16'(next_level_khz) * 16'h0028;
  end
endmodule

// file: test/test_thermal_derating_fan_control.sv
// apb driven test of derating and fan control
`timescale 1ns/1ps
module test_thermal_derating_fan_control;
  import thermal_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, drive_enable = 1;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, d;
  logic pready, pslverr, fan_half, fan_full, ext_fan_out, device_fault, err;
  logic signed [7:0] hs = 20, tin = 20, cap = 20, heatsink_temp, inside_temp, cap_temp;
  logic [15:0] cur = 0, output_current, overload_current, next_level_current;
  logic [4:0] switch_freq_khz, next_level_khz, f_prev;
  int mismatches = 0, tests_run = 0;
  always #5 pclk = ~pclk;
  thermal_plant_model plant (.pclk(pclk), .hs_cmd(hs), .in_cmd(tin), .cap_cmd(cap),
    .cur_cmd(cur), .next_level_khz(next_level_khz), .heatsink_temp(heatsink_temp),
    .inside_temp(inside_temp), .cap_temp(cap_temp), .output_current(output_current),
    .overload_current(overload_current), .next_level_current(next_level_current));
  thermal_derating_fan_control #(.EVAL_PERIOD(4)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .heatsink_temp(heatsink_temp),
    .inside_temp(inside_temp), .cap_temp(cap_temp), .output_current(output_current),
    .overload_current(overload_current), .next_level_current(next_level_current),
    .drive_enable(drive_enable), .switch_freq_khz(switch_freq_khz),
    .next_level_khz(next_level_khz), .fan_half(fan_half), .fan_full(fan_full),
    .ext_fan_out(ext_fan_out), .device_fault(device_fault));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1, a, wd);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(0, a, 0);
    chk(d, exp);
  endtask
  // waits n evaluation periods plus the sensor and output delays
  task tk(input int n);
    repeat (n * 4 + 3) @(posedge pclk);
    #1;
  endtask
  // frequency never jumps more than one level between samples
  always @(posedge pclk) begin
    if (presetn && f_prev !== switch_freq_khz) chk((f_prev > switch_freq_khz ?
      f_prev - switch_freq_khz : switch_freq_khz - f_prev) <= 2, 1);
    f_prev <= switch_freq_khz;
  end
  initial begin
    #100000;
    mismatches++;
    results();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rd(ADDR_CTRL, 32'h00000004);
    rd(ADDR_NOM_FREQ, 32'h00000002);
    rd(ADDR_MIN_FREQ, 32'h00000002);
    rd(ADDR_OFFSET, 32'hFFFFFFFC);
    rd(ADDR_FAN_TEMP, 32'h0000001E);
    wr(ADDR_CTRL, 32'h00000005);
    rd(ADDR_NOM_FREQ, 32'h00000004);
    wr(ADDR_NOM_FREQ, 32'h00000020);
    rd(ADDR_NOM_FREQ, 32'h00000010);
    // let the frequency climb to nominal before the band collapses
    tk(8);
    wr(ADDR_MIN_FREQ, 32'h00000001);
    rd(ADDR_MIN_FREQ, 32'h00000002);
    wr(ADDR_MIN_FREQ, 32'h00000011);
    rd(ADDR_MIN_FREQ, 32'h00000010);
    // minimum kept far above ten times any output frequency used here
    wr(ADDR_MIN_FREQ, 32'h00000008);
    wr(ADDR_OFFSET, -32'sd30);
    rd(ADDR_OFFSET, 32'hFFFFFFE7);
    wr(ADDR_OFFSET, 32'h00000005);
    rd(ADDR_OFFSET, 32'h00000000);
    wr(ADDR_OFFSET, -32'sd4);
    xfer(0, 8'h40, 0);
    chk({err, d}, 33'h100000000);
    tk(10);
    chk(switch_freq_khz, 16);
    hs <= 87;
    repeat (5) @(posedge pclk);
    #1;
    chk(switch_freq_khz inside {12, 14}, 1);
    tk(10);
    chk(switch_freq_khz, 8);
    hs <= 81;
    tk(3);
    chk(switch_freq_khz, 8);
    hs <= 80;
    tk(10);
    chk(switch_freq_khz, 16);
    hs <= 20;
    cur <= 701;
    tk(10);
    chk(switch_freq_khz, 8);
    tk(2);
    chk(switch_freq_khz, 8);
    chk(next_level_khz, 10);
    cur <= 200;
    tk(10);
    chk(switch_freq_khz, 16);
    wr(ADDR_CTRL, 32'h00002B01);
    cur <= 750;
    tk(5);
    chk(switch_freq_khz, 16);
    cur <= 0;
    wr(ADDR_MIN_FREQ, 32'h00000010);
    hs <= 87;
    tk(5);
    chk(switch_freq_khz, 16);
    hs <= 20;
    tin <= 31;
    tk(2);
    chk({fan_half, ext_fan_out}, 2'b11);
    tin <= 26;
    tk(2);
    chk(fan_half, 1);
    tin <= 24;
    tk(2);
    chk({fan_half, ext_fan_out}, 2'b00);
    wr(ADDR_FAN_TEMP, 32'h0000003C);
    tin <= 56;
    tk(2);
    chk(fan_half, 1);
    tin <= 49;
    tk(2);
    chk(fan_half, 0);
    cap <= 76;
    tk(3);
    chk(fan_full, 1);
    // the earlier heat-sink excursion left the fault set: clear it first
    wr(ADDR_STATUS, 32'h00000400);
    xfer(0, ADDR_STATUS, 0);
    chk(d[STAT_FAULT_BIT], 0);
    cap <= 20;
    tin <= 86;
    tk(1);
    chk(device_fault, 1);
    tin <= 20;
    tk(2);
    chk(device_fault, 1);
    wr(ADDR_STATUS, 32'h00000400);
    xfer(0, ADDR_STATUS, 0);
    chk(d[STAT_FAULT_BIT], 0);
    wr(ADDR_CTRL, 32'h00002B03);
    @(posedge pclk);
    drive_enable <= 0;
    tin <= 57;
    tk(2);
    chk(fan_half, 0);
    @(posedge pclk);
    drive_enable <= 1;
    tk(2);
    chk(fan_half, 1);
    results();
  end
endmodule
